// ---- brl_pkg.sv ----
// package for the bus remote/lockout and service request block
// assumes a single 250 MHz system clock domain
package brl_pkg;

	// remote/local control states, one-hot
	typedef enum logic [3:0] {
		BRL_LOCAL      = 4'h1,
		BRL_REMOTE     = 4'h2,
		BRL_LOCAL_LOCK = 4'h4,
		BRL_REMOTE_LOCK = 4'h8
	} brl_rl_state_type;

	// service request states, one-hot
	typedef enum logic [1:0] {
		BRL_SRQ_IDLE   = 2'h1,
		BRL_SRQ_ACTIVE = 2'h2
	} brl_srq_state_type;

	localparam logic [1:0] BRL_SYNC_RESET = 2'h0;

endpackage : brl_pkg

// ---- brl_srq.sv ----
// service request line handling
// assumes synchronous pulses from the bus decoder and rst_n already synchronised
`timescale 1ns/100ps
module brl_srq (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic service_needed,
	input  wire logic poll_byte_read,
	output logic      srq_asserted
);

	brl_pkg::brl_srq_state_type state_reg;
	brl_pkg::brl_srq_state_type state_next;
	logic                       need_d_reg;
	logic                       need_d_next;

	// next-state: raise on new need, drop on poll or condition gone
	always_comb begin
		state_next  = state_reg;
		need_d_next = service_needed;
		case (state_reg)
			brl_pkg::BRL_SRQ_IDLE: begin
				if (service_needed && !need_d_reg)
					state_next = brl_pkg::BRL_SRQ_ACTIVE; // [RL5]
			end
			brl_pkg::BRL_SRQ_ACTIVE: begin
				if (!service_needed)
					state_next = brl_pkg::BRL_SRQ_IDLE; // [RL6]
				else if (poll_byte_read)
					state_next = brl_pkg::BRL_SRQ_IDLE; // [RL9]
			end
			default: state_next = brl_pkg::BRL_SRQ_IDLE;
		endcase
		// a fresh condition in the poll cycle wins over the release
		if (service_needed && !need_d_reg)
			state_next = brl_pkg::BRL_SRQ_ACTIVE; // [RL9]
	end

	// state registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg  <= brl_pkg::BRL_SRQ_IDLE;
			need_d_reg <= 1'b0;
		end else begin
			state_reg  <= state_next;
			need_d_reg <= need_d_next;
		end
	end

	assign srq_asserted = (state_reg == brl_pkg::BRL_SRQ_ACTIVE);

	property p_srq_rise;
		@(posedge mclk) disable iff (!rst_n)
		(service_needed && !need_d_reg) |=> srq_asserted;
	endproperty
	a_srq_rise: assert property (p_srq_rise) else $error("srq not raised on new need"); // [RL5]

	property p_srq_hold;
		@(posedge mclk) disable iff (!rst_n)
		(srq_asserted && service_needed && !poll_byte_read) |=> srq_asserted;
	endproperty
	a_srq_hold: assert property (p_srq_hold) else $error("srq dropped early"); // [RL6]

	property p_srq_gone;
		@(posedge mclk) disable iff (!rst_n)
		(srq_asserted && !service_needed) |=> !srq_asserted;
	endproperty
	a_srq_gone: assert property (p_srq_gone) else $error("srq held without need"); // [RL6]

	property p_srq_poll;
		@(posedge mclk) disable iff (!rst_n)
		(srq_asserted && poll_byte_read && need_d_reg) |=> !srq_asserted;
	endproperty
	a_srq_poll: assert property (p_srq_poll) else $error("srq held after poll"); // [RL9]

endmodule : brl_srq

// ---- brl_top.sv ----
// remote/local/lockout tracking and service request for a bus instrument
// assumes the bus message decoder delivers one-cycle pulses synchronous to mclk
`timescale 1ns/100ps
// Functional notes
// [RL1] In lockout the front-panel local request is ignored and bus control stays.
// [RL2] The controller sends lockout only while the bus is in command mode.
// [RL3] The controller clears lockout by driving remote enable false.
// [RL4] Remote enable going false forces local and clears lockout whatever the addressing.
// [RL5] The instrument drives the service request line true when it needs attention.
// [RL6] Service request stays true until polled or until the need is gone.
// [RL7] With remote enable true the instrument stays local until addressed, then goes remote.
// [RL8] An addressed local message as listener returns the instrument to local, remote enable unchanged.
// [RL9] Service request is released once the status byte is read in a serial poll unless a new need arises.
module brl_top (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic ren,
	input  wire logic atn,
	input  wire logic addressed_pulse,
	input  wire logic go_local_pulse,
	input  wire logic lockout_pulse,
	input  wire logic panel_local_req,
	input  wire logic service_needed,
	input  wire logic poll_byte_read,
	output logic      remote_mode,
	output logic      lockout_mode,
	output logic      srq_out,
	output logic      srq_oe
);

	logic [1:0]                rst_sync_reg;
	logic                      rst_n;
	brl_pkg::brl_rl_state_type state_reg;
	brl_pkg::brl_rl_state_type state_next;
	logic                      remote_reg;
	logic                      remote_next;
	logic                      lockout_next;
	logic                      addr_take;
	logic                      lockout_reg;
	logic                      srq_line;

	// reset release through two flip-flops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			rst_sync_reg <= brl_pkg::BRL_SYNC_RESET;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// addressing counts unless the same cycle carries go-local, which wins
	assign addr_take = addressed_pulse && !go_local_pulse;

	// remote/local state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			brl_pkg::BRL_LOCAL: begin
				if (lockout_pulse && atn) // [RL2]
					state_next = addr_take ? brl_pkg::BRL_REMOTE_LOCK : brl_pkg::BRL_LOCAL_LOCK;
				else if (addr_take)
					state_next = brl_pkg::BRL_REMOTE; // [RL7]
			end
			brl_pkg::BRL_REMOTE: begin
				if (go_local_pulse)
					state_next = brl_pkg::BRL_LOCAL; // [RL8]
				else if (lockout_pulse && atn)
					state_next = brl_pkg::BRL_REMOTE_LOCK;
				else if (panel_local_req && !addressed_pulse)
					state_next = brl_pkg::BRL_LOCAL; // addressing in the same cycle keeps remote
			end
			brl_pkg::BRL_LOCAL_LOCK: begin
				if (addr_take)
					state_next = brl_pkg::BRL_REMOTE_LOCK; // [RL7]
			end
			brl_pkg::BRL_REMOTE_LOCK: begin
				// panel request has no effect here
				if (go_local_pulse)
					state_next = brl_pkg::BRL_LOCAL_LOCK; // [RL8]
				else
					state_next = brl_pkg::BRL_REMOTE_LOCK; // [RL1]
			end
			default: state_next = brl_pkg::BRL_LOCAL;
		endcase
		// remote enable false overrides everything
		if (!ren)
			state_next = brl_pkg::BRL_LOCAL; // [RL4]
		// mode flags follow the next state
		remote_next  = (state_next == brl_pkg::BRL_REMOTE) || (state_next == brl_pkg::BRL_REMOTE_LOCK);
		lockout_next = (state_next == brl_pkg::BRL_LOCAL_LOCK) || (state_next == brl_pkg::BRL_REMOTE_LOCK);
	end

	// state and output registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= brl_pkg::BRL_LOCAL;
			remote_reg  <= 1'b0;
			lockout_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			remote_reg  <= remote_next;
			lockout_reg <= lockout_next;
		end
	end

	assign remote_mode  = remote_reg;
	assign lockout_mode = lockout_reg;

	// service request engine
	brl_srq u_srq (
		.mclk           (mclk),
		.rst_n          (rst_n),
		.service_needed (service_needed),
		.poll_byte_read (poll_byte_read),
		.srq_asserted   (srq_line)
	);

	// open-drain line: pull low only while requesting
	assign srq_out = 1'b0;
	assign srq_oe  = srq_line; // [RL5]

	property p_lock_panel;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == brl_pkg::BRL_REMOTE_LOCK && ren && !go_local_pulse && panel_local_req) |=> remote_mode;
	endproperty
	a_lock_panel: assert property (p_lock_panel) else $error("panel escaped lockout"); // [RL1]

	property p_ren_drop;
		@(posedge mclk) disable iff (!rst_n)
		!ren |=> (!remote_mode && !lockout_mode);
	endproperty
	a_ren_drop: assert property (p_ren_drop) else $error("ren false did not force local"); // [RL4]

	property p_stay_local;
		@(posedge mclk) disable iff (!rst_n)
		(ren && !remote_mode && !addressed_pulse) |=> !remote_mode;
	endproperty
	a_stay_local: assert property (p_stay_local) else $error("went remote unaddressed"); // [RL7]

	property p_addr_remote;
		@(posedge mclk) disable iff (!rst_n)
		(ren && addressed_pulse && !go_local_pulse) |=> remote_mode;
	endproperty
	a_addr_remote: assert property (p_addr_remote) else $error("not remote after addressing"); // [RL7]

	property p_go_local;
		@(posedge mclk) disable iff (!rst_n)
		(go_local_pulse && remote_mode) |=> !remote_mode;
	endproperty
	a_go_local: assert property (p_go_local) else $error("addressed local ignored"); // [RL8]

	property p_lock_hold;
		@(posedge mclk) disable iff (!rst_n)
		(lockout_mode && ren) |=> lockout_mode;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lockout left with remote enable true"); // [RL1]

	property p_lock_remote;
		@(posedge mclk) disable iff (!rst_n)
		(remote_mode && lockout_mode && ren && !go_local_pulse) |=> remote_mode;
	endproperty
	a_lock_remote: assert property (p_lock_remote) else $error("remote lost in lockout"); // [RL1]

	property p_lock_enter;
		@(posedge mclk) disable iff (!rst_n)
		(ren && atn && lockout_pulse && !go_local_pulse) |=> lockout_mode;
	endproperty
	a_lock_enter: assert property (p_lock_enter) else $error("lockout not entered"); // [RL2]

	property p_lock_cmd;
		@(posedge mclk) disable iff (!rst_n)
		(!lockout_mode && lockout_pulse && !atn) |=> !lockout_mode;
	endproperty
	a_lock_cmd: assert property (p_lock_cmd) else $error("lockout taken outside command mode"); // [RL2]

endmodule : brl_top

// ---- brl_ctrl_model.sv ----
// controller model: remote enable, attention and decoded bus messages
// assumes the bench calls its tasks; one mclk domain
`timescale 1ns/100ps
module brl_ctrl_model (
	input  wire logic mclk,
	output logic      ren,
	output logic      atn,
	output logic      addressed_pulse,
	output logic      go_local_pulse,
	output logic      lockout_pulse,
	output logic      poll_byte_read
);
	// idle bus at time zero
	initial begin
		{ren, atn, addressed_pulse, go_local_pulse, lockout_pulse, poll_byte_read} = 6'h00;
	end
	// remote enable level, settled one edge later
	task automatic set_ren(input logic v);
		@(posedge mclk);
		ren <= v; // false clears lockout
		@(posedge mclk);
	endtask : set_ren
	// lockout pulse outside command mode, a case the design must refuse
	task automatic lockout_no_cmd;
		@(posedge mclk);
		lockout_pulse <= 1'b1;
		@(posedge mclk);
		lockout_pulse <= 1'b0;
	endtask : lockout_no_cmd
	// one message: 0 address, 1 lockout, 2 local, 3 poll
	task automatic msg(input logic [1:0] kind);
		@(posedge mclk);
		atn <= 1'b1;
		@(posedge mclk);
		addressed_pulse <= (kind == 2'h0);
		lockout_pulse   <= (kind == 2'h1); // only in command mode
		go_local_pulse  <= (kind == 2'h2);
		poll_byte_read  <= (kind == 2'h3);
		@(posedge mclk);
		{addressed_pulse, lockout_pulse, go_local_pulse, poll_byte_read, atn} <= 5'h00;
	endtask : msg
endmodule : brl_ctrl_model

// ---- bus_remote_lockout_service_request_test.sv ----
// bench for remote/lockout tracking and service request
// assumes brl_top and brl_ctrl_model compiled first
`timescale 1ns/100ps
module bus_remote_lockout_service_request_test;
	logic       mclk, rstn, panel_local_req, service_needed, remote_mode, lockout_mode, srq_out, srq_oe;
	logic       ren, atn, addressed_pulse, go_local_pulse, lockout_pulse, poll_byte_read;
	logic [1:0] st, op;
	int         failures, comparisons, cycles;
	brl_top brl_top_inst (.mclk(mclk), .rstn(rstn), .ren(ren), .atn(atn), .addressed_pulse(addressed_pulse),
		.go_local_pulse(go_local_pulse), .lockout_pulse(lockout_pulse), .panel_local_req(panel_local_req),
		.service_needed(service_needed), .poll_byte_read(poll_byte_read), .remote_mode(remote_mode),
		.lockout_mode(lockout_mode), .srq_out(srq_out), .srq_oe(srq_oe));
	brl_ctrl_model brl_ctrl_model_inst (.mclk(mclk), .ren(ren), .atn(atn), .addressed_pulse(addressed_pulse),
		.go_local_pulse(go_local_pulse), .lockout_pulse(lockout_pulse), .poll_byte_read(poll_byte_read));
	// clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// expected {lockout, remote} after an operation
	function automatic logic [1:0] next_st(input logic [1:0] s, input logic [1:0] o);
		case (o)
			2'h0: return s | 2'h1;
			2'h1: return s | 2'h2;
			2'h2: return s & 2'h2;
			default: return s[1] ? s : 2'h0;
		endcase
	endfunction : next_st
	task automatic check_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %b wanted %b", $time, got, exp);
		end
	endtask : check_bit
	task automatic check_mode(input logic [1:0] exp);
		@(negedge mclk);
		check_bit(lockout_mode, exp[1]);
		check_bit(remote_mode, exp[0]);
	endtask : check_mode
	task automatic pulse_panel;
		@(posedge mclk);
		panel_local_req <= 1'b1;
		@(posedge mclk);
		panel_local_req <= 1'b0;
	endtask : pulse_panel
	task automatic stop_test;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	// hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			stop_test();
		end
	end
	// main sequence
	initial begin
		{rstn, panel_local_req, service_needed} = 3'h0;
		{failures, comparisons, cycles} = '0;
		void'($urandom(32'heaf6be93));
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		brl_ctrl_model_inst.set_ren(1'b1);
		check_mode(2'h0); // enable alone stays local
		brl_ctrl_model_inst.lockout_no_cmd();
		check_mode(2'h0);
		st = 2'h0;
		for (int i = 0; i < 40; i++) begin
			op = (i < 4) ? 2'(8'h8d >> (2 * i)) : 2'($urandom_range(3));
			if (op == 2'h3) pulse_panel();
			else brl_ctrl_model_inst.msg(op);
			st = next_st(st, op);
			check_mode(st);
			if (i % 10 == 9) begin
				brl_ctrl_model_inst.set_ren(1'b0);
				st = 2'h0;
				check_mode(st);
				brl_ctrl_model_inst.set_ren(1'b1);
			end
		end
		@(posedge mclk);
		service_needed <= 1'b1;
		repeat (2) @(negedge mclk);
		check_bit(srq_oe, 1'b1);
		check_bit(srq_out, 1'b0);
		repeat (5) @(negedge mclk);
		check_bit(srq_oe, 1'b1);
		brl_ctrl_model_inst.msg(2'h3);
		@(negedge mclk);
		check_bit(srq_oe, 1'b0);
		@(posedge mclk);
		service_needed <= 1'b0;
		@(posedge mclk);
		service_needed <= 1'b1;
		@(posedge mclk);
		service_needed <= 1'b0;
		@(negedge mclk);
		check_bit(srq_oe, 1'b1);
		@(negedge mclk);
		check_bit(srq_oe, 1'b0);
		fork
			brl_ctrl_model_inst.msg(2'h3);
			begin
				repeat (2) @(posedge mclk);
				service_needed <= 1'b1;
			end
		join
		@(negedge mclk);
		check_bit(srq_oe, 1'b1);
		brl_ctrl_model_inst.msg(2'h3);
		@(negedge mclk);
		check_bit(srq_oe, 1'b0);
		@(negedge mclk);
		check_bit(srq_oe, 1'b0);
		stop_test();
	end
endmodule : bus_remote_lockout_service_request_test
